// *** hw/pti_timestamp_input.sv ***
// Two event timestamp input units with APB registers and interrupt
// How it works
// - Status reports detected edge count, four bits
// - Single mode captures up to fifteen events
// - Edges resolved up to 25 MHz
// - Extra edge when full sets overflow, saturates
// - In cascade only tail unit flags overflow
// - Control bit enables rising edge capture
// - Control bit enables falling edge capture
// - Control bit marks unit as chain tail
// - Control bit selects upstream unit done input
// - Control bit puts unit in cascade
// - Each sample records edge polarity
// - Each sample stores thirty-bit nanoseconds
// - Each sample stores thirty-two-bit seconds
// - Each sample stores 8 ns slot phase
// - Sample registers follow the unit index pointer
// - Second and third sample records exist too
`timescale 1ns/100ps
`default_nettype none
module pti_timestamp_input
    import pti_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         clk_en,
    input  wire pti_apb_req_t apb_req,
    output pti_apb_rsp_t      apb_rsp,
    input  wire pti_time_t    ptp_time,
    input  wire logic [1:0]   event_in,
    output logic              irq
);

    pti_state_t s;
    pti_state_t next_s;

    logic [UNITS-1:0]    rise;
    logic [UNITS-1:0]    fall;
    logic [UNITS-1:0]    hit;
    logic [UNITS-1:0]    armed;
    logic [UNITS-1:0]    cap;
    logic [UNITS-1:0]    ovf_ev;
    logic [IRQ_BITS-1:0] irq_clr;
    logic                wr_en;
    logic                rd_setup;
    logic                mapped;
    logic [31:0]         rv;
    pti_unit_t           sel;

    assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable;
    assign sel      = s.unit[s.idx];

    always_comb begin
        next_s  = s;
        irq_clr = '0;
        rise    = '0;
        fall    = '0;
        hit     = '0;
        armed   = '0;
        cap     = '0;
        ovf_ev  = '0;
        mapped  = 1'b0;
        rv      = '0;

        // Free-running slot position inside the 40 ns event period
        next_s.slot = (s.slot == SLOT_LAST) ? 3'h0 : s.slot + 3'h1;

        // Zero-wait writes; control goes to the indexed unit
        if (wr_en) begin
            if (apb_req.paddr == OFF_CTRL) begin
                next_s.unit[s.idx].rise_detect_en  = apb_req.pwdata[RISE_BIT];
                next_s.unit[s.idx].fall_detect_en  = apb_req.pwdata[FALL_BIT];
                next_s.unit[s.idx].chain_last_unit = apb_req.pwdata[TAIL_BIT];
                next_s.unit[s.idx].upstream_select = apb_req.pwdata[UPSEL_BIT];
                next_s.unit[s.idx].chain_enable    = apb_req.pwdata[CHAIN_BIT];
                // Writing one to the overflow position rearms the unit
                if (apb_req.pwdata[OVF_BIT]) begin
                    next_s.unit[s.idx].detected_edge_count = '0;
                    next_s.unit[s.idx].edge_count_overflow = 1'b0;
                    next_s.unit[s.idx].smp                 = '0;
                end
            end else if (apb_req.paddr == OFF_INDEX) begin
                next_s.idx = apb_req.pwdata[IDX_BIT];
            end else if (apb_req.paddr == OFF_IRQ_STAT) begin
                irq_clr = apb_req.pwdata[IRQ_BITS-1:0];
            end else if (apb_req.paddr == OFF_IRQ_MASK) begin
                next_s.irq_mask = apb_req.pwdata[IRQ_BITS-1:0];
            end
        end

        // One sample per 8 ns clock resolves 25 MHz edge trains
        for (int u = 0; u < UNITS; u++) begin
            rise[u] = event_in[u] & ~s.unit[u].prev_in;
            fall[u] = ~event_in[u] & s.unit[u].prev_in;
            next_s.unit[u].prev_in = event_in[u];
            hit[u] = (rise[u] & next_s.unit[u].rise_detect_en)
                   | (fall[u] & next_s.unit[u].fall_detect_en);
            // Head selects itself; others wait until upstream is full
            armed[u] = ~next_s.unit[u].chain_enable
                     | (next_s.unit[u].upstream_select == u[0])
                     | (s.unit[next_s.unit[u].upstream_select].detected_edge_count
                        == COUNT_MAX);
            if (hit[u] & armed[u]) begin
                if (next_s.unit[u].detected_edge_count == COUNT_MAX) begin
                    // Non-tail units in a chain hand overflow downstream
                    if (~next_s.unit[u].chain_enable | next_s.unit[u].chain_last_unit) begin
                        next_s.unit[u].edge_count_overflow = 1'b1;
                        ovf_ev[u] = 1'b1;
                    end
                end else begin
                    cap[u] = 1'b1;
                    if (next_s.unit[u].detected_edge_count < SAMPLES_CNT) begin
                        next_s.unit[u].smp[next_s.unit[u].detected_edge_count[1:0]] = '{
                            pol: rise[u],
                            ns:  ptp_time.ns,
                            sec: ptp_time.sec,
                            ph:  pti_phase_code(s.slot)
                        };
                    end
                    next_s.unit[u].detected_edge_count =
                        next_s.unit[u].detected_edge_count + 4'h1;
                end
            end
        end

        // New events win over a write-one clear in the same cycle
        next_s.irq_stat = (s.irq_stat & ~irq_clr) | {ovf_ev, cap};

        // Read data latched in setup so it is stable in access
        if (rd_setup) begin
            if (apb_req.paddr == OFF_CTRL) begin
                mapped = 1'b1;
                rv[CNT_MSB:CNT_LSB] = sel.detected_edge_count;
                rv[OVF_BIT]   = sel.edge_count_overflow;
                rv[RISE_BIT]  = sel.rise_detect_en;
                rv[FALL_BIT]  = sel.fall_detect_en;
                rv[TAIL_BIT]  = sel.chain_last_unit;
                rv[UPSEL_BIT] = sel.upstream_select;
                rv[CHAIN_BIT] = sel.chain_enable;
            end else if (apb_req.paddr == OFF_INDEX) begin
                mapped = 1'b1;
                rv[IDX_BIT] = s.idx;
            end else if (apb_req.paddr == OFF_IRQ_STAT) begin
                mapped = 1'b1;
                rv[IRQ_BITS-1:0] = s.irq_stat;
            end else if (apb_req.paddr == OFF_IRQ_MASK) begin
                mapped = 1'b1;
                rv[IRQ_BITS-1:0] = s.irq_mask;
            end
            for (int k = 0; k < SAMPLES; k++) begin
                if (apb_req.paddr == OFF_SMP_NS + 12'(k) * SMP_STRIDE) begin
                    mapped = 1'b1;
                    rv[POL_BIT]      = sel.smp[k].pol;
                    rv[NS_MSB:0]     = sel.smp[k].ns;
                end else if (apb_req.paddr == OFF_SMP_SEC + 12'(k) * SMP_STRIDE) begin
                    mapped = 1'b1;
                    rv = sel.smp[k].sec;
                end else if (apb_req.paddr == OFF_SMP_PH + 12'(k) * SMP_STRIDE) begin
                    mapped = 1'b1;
                    rv[PH_MSB:0] = sel.smp[k].ph;
                end
            end
            next_s.rdata = rv;
            next_s.err   = ~mapped;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= STATE_RESET;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign apb_rsp.prdata  = s.rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = s.err & apb_req.psel & apb_req.penable;
    assign irq             = |(s.irq_stat & s.irq_mask);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_ovf_sat;
        s.unit[0].edge_count_overflow |-> s.unit[0].detected_edge_count == COUNT_MAX;
    endproperty
    a_ovf_sat: assert property (p_ovf_sat) else $error("overflow without full count");

    property p_cnt_step;
        clk_en && cap[0] && !wr_en |=>
            s.unit[0].detected_edge_count == $past(s.unit[0].detected_edge_count) + 4'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count did not step");

    property p_rise_off;
        clk_en && !wr_en && !s.unit[0].rise_detect_en && rise[0] |-> !cap[0] && !ovf_ev[0];
    endproperty
    a_rise_off: assert property (p_rise_off) else $error("rising edge taken while off");

    property p_fall_off;
        clk_en && !wr_en && !s.unit[0].fall_detect_en && fall[0] |-> !cap[0] && !ovf_ev[0];
    endproperty
    a_fall_off: assert property (p_fall_off) else $error("falling edge taken while off");

    property p_first_smp;
        clk_en && !wr_en && cap[0] && s.unit[0].detected_edge_count == 4'h0 |=>
            s.unit[0].smp[0].pol == $past(event_in[0])
            && s.unit[0].smp[0].ns == $past(ptp_time.ns)
            && s.unit[0].smp[0].sec == $past(ptp_time.sec);
    endproperty
    a_first_smp: assert property (p_first_smp) else $error("first record wrong");

    property p_phase;
        clk_en && !wr_en && cap[0] && s.unit[0].detected_edge_count == 4'h1 |=>
            s.unit[0].smp[1].ph == pti_phase_code($past(s.slot));
    endproperty
    a_phase: assert property (p_phase) else $error("phase slot wrong");

    property p_tail_only;
        clk_en && !wr_en && s.unit[0].chain_enable && !s.unit[0].chain_last_unit
            && !s.unit[0].edge_count_overflow |=> !s.unit[0].edge_count_overflow;
    endproperty
    a_tail_only: assert property (p_tail_only) else $error("non-tail set overflow");

    property p_cnt_read;
        clk_en && rd_setup && apb_req.paddr == OFF_CTRL ##1 apb_req.psel && apb_req.penable
            |-> apb_rsp.prdata[CNT_MSB:CNT_LSB] == $past(sel.detected_edge_count)
                && apb_rsp.pready;
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("count read back wrong");

    property p_index_read;
        clk_en && rd_setup && apb_req.paddr == OFF_SMP_SEC |=>
            apb_rsp.prdata == $past(s.unit[s.idx].smp[0].sec);
    endproperty
    a_index_read: assert property (p_index_read) else $error("index select wrong");

    // Unit 1 mirrors the unit 0 overflow, count step, tail and edge enable checks; chain gating is not symmetric
    property p_ovf_sat_u1;
        s.unit[1].edge_count_overflow |-> s.unit[1].detected_edge_count == COUNT_MAX;
    endproperty
    a_ovf_sat_u1: assert property (p_ovf_sat_u1) else $error("u1 overflow early");

    property p_cnt_step_u1;
        clk_en && cap[1] && !wr_en |=>
            s.unit[1].detected_edge_count == $past(s.unit[1].detected_edge_count) + 4'h1;
    endproperty
    a_cnt_step_u1: assert property (p_cnt_step_u1) else $error("u1 count did not step");

    // Count moves only on a capture or a rearm write
    property p_cnt_hold;
        clk_en && !wr_en && !cap[0] |=> $stable(s.unit[0].detected_edge_count);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved alone");

    property p_ovf_sticky;
        clk_en && !wr_en && s.unit[0].edge_count_overflow |=> s.unit[0].edge_count_overflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");

    property p_full_no_cap;
        clk_en && !wr_en && s.unit[0].detected_edge_count == COUNT_MAX |-> !cap[0];
    endproperty
    a_full_no_cap: assert property (p_full_no_cap) else $error("capture past fifteen");

    property p_tail_only_u1;
        clk_en && !wr_en && s.unit[1].chain_enable && !s.unit[1].chain_last_unit
            && !s.unit[1].edge_count_overflow |=> !s.unit[1].edge_count_overflow;
    endproperty
    a_tail_only_u1: assert property (p_tail_only_u1) else $error("u1 non-tail overflow");

    property p_rise_off_u1;
        clk_en && !wr_en && !s.unit[1].rise_detect_en && rise[1] |-> !cap[1] && !ovf_ev[1];
    endproperty
    a_rise_off_u1: assert property (p_rise_off_u1) else $error("u1 rise taken");

    property p_fall_off_u1;
        clk_en && !wr_en && !s.unit[1].fall_detect_en && fall[1] |-> !cap[1] && !ovf_ev[1];
    endproperty
    a_fall_off_u1: assert property (p_fall_off_u1) else $error("u1 fall taken");

    // Control fields land in the indexed unit only
    property p_ctrl_edges;
        clk_en && wr_en && apb_req.paddr == OFF_CTRL && !s.idx |=>
            s.unit[0].rise_detect_en == $past(apb_req.pwdata[RISE_BIT])
            && s.unit[0].fall_detect_en == $past(apb_req.pwdata[FALL_BIT]);
    endproperty
    a_ctrl_edges: assert property (p_ctrl_edges) else $error("enables lost");

    property p_ctrl_chain;
        clk_en && wr_en && apb_req.paddr == OFF_CTRL && s.idx |=>
            s.unit[1].upstream_select == $past(apb_req.pwdata[UPSEL_BIT])
            && s.unit[1].chain_enable == $past(apb_req.pwdata[CHAIN_BIT]);
    endproperty
    a_ctrl_chain: assert property (p_ctrl_chain) else $error("chain lost");

    property p_ctrl_tail;
        clk_en && wr_en && apb_req.paddr == OFF_CTRL && !s.idx |=>
            s.unit[0].chain_last_unit == $past(apb_req.pwdata[TAIL_BIT]);
    endproperty
    a_ctrl_tail: assert property (p_ctrl_tail) else $error("tail bit lost");

    // Rearm restarts the record sequence; a same-cycle edge may count once
    property p_rearm;
        clk_en && wr_en && apb_req.paddr == OFF_CTRL && apb_req.pwdata[OVF_BIT] && !s.idx |=>
            !s.unit[0].edge_count_overflow && s.unit[0].detected_edge_count <= 4'h1;
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm did not clear");

    property p_third_smp;
        clk_en && !wr_en && cap[0] && s.unit[0].detected_edge_count == 4'h2 |=>
            s.unit[0].smp[2].pol == $past(event_in[0])
            && s.unit[0].smp[2].ns == $past(ptp_time.ns)
            && s.unit[0].smp[2].sec == $past(ptp_time.sec);
    endproperty
    a_third_smp: assert property (p_third_smp) else $error("third record wrong");

    // Captures four to fifteen only count; records stay put
    property p_rec_frozen;
        clk_en && !wr_en && cap[0] && s.unit[0].detected_edge_count >= SAMPLES_CNT |=>
            $stable(s.unit[0].smp);
    endproperty
    a_rec_frozen: assert property (p_rec_frozen) else $error("record overwritten");

    property p_slot_step;
        clk_en && s.slot != SLOT_LAST |=> s.slot == $past(s.slot) + 3'h1;
    endproperty
    a_slot_step: assert property (p_slot_step) else $error("slot did not step");

    property p_slot_wrap;
        clk_en && s.slot == SLOT_LAST |=> s.slot == 3'h0;
    endproperty
    a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");

    // Codes above the 32 ns slot are reserved and never stored
    property p_phase_legal;
        s.unit[0].smp[0].ph <= PH_32NS && s.unit[1].smp[0].ph <= PH_32NS;
    endproperty
    a_phase_legal: assert property (p_phase_legal) else $error("reserved phase code");

    property p_index_write;
        clk_en && wr_en && apb_req.paddr == OFF_INDEX |=> s.idx == $past(apb_req.pwdata[IDX_BIT]);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index not taken");

    property p_ovf_irq;
        clk_en && ovf_ev[0] |=> s.irq_stat[2];
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow not flagged");

    property p_cap_irq;
        clk_en && cap[1] |=> s.irq_stat[1];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("u1 capture not flagged");

    // A chained unit waits until its upstream unit is full, unless it selects itself as head
    property p_chain_gate;
        clk_en && !wr_en && s.unit[1].chain_enable && !s.unit[1].upstream_select
            && s.unit[0].detected_edge_count != COUNT_MAX |-> !cap[1] && !ovf_ev[1];
    endproperty
    a_chain_gate: assert property (p_chain_gate) else $error("chained unit not gated");

    property p_head_free;
        clk_en && !wr_en && s.unit[0].chain_enable && !s.unit[0].upstream_select && hit[0]
            && s.unit[0].detected_edge_count != COUNT_MAX |-> cap[0];
    endproperty
    a_head_free: assert property (p_head_free) else $error("head unit blocked");

    property p_single_free;
        clk_en && !wr_en && !s.unit[1].chain_enable && hit[1]
            && s.unit[1].detected_edge_count != COUNT_MAX |-> cap[1];
    endproperty
    a_single_free: assert property (p_single_free) else $error("u1 edge missed");

    // Edges one clock apart must all be resolved
    property p_edge_rate;
        clk_en && !wr_en && !s.unit[0].chain_enable && hit[0]
            && s.unit[0].detected_edge_count != COUNT_MAX |-> cap[0];
    endproperty
    a_edge_rate: assert property (p_edge_rate) else $error("edge missed");

endmodule
`default_nettype wire

// *** hw/pti_pkg.sv ***
// Constants, layouts and carriers for the event timestamp input block
package pti_pkg;

    localparam int UNITS   = 2;
    localparam int SAMPLES = 3;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL     = 12'h550;
    localparam logic [11:0] OFF_SMP_NS   = 12'h554;
    localparam logic [11:0] OFF_SMP_SEC  = 12'h558;
    localparam logic [11:0] OFF_SMP_PH   = 12'h55c;
    localparam logic [11:0] SMP_STRIDE   = 12'h00c;
    localparam logic [11:0] OFF_INDEX    = 12'h580;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h584;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h588;

    // Control and status field positions
    localparam int CNT_MSB   = 20;
    localparam int CNT_LSB   = 17;
    localparam int OVF_BIT   = 16;
    localparam int RISE_BIT  = 7;
    localparam int FALL_BIT  = 6;
    localparam int TAIL_BIT  = 5;
    localparam int UPSEL_BIT = 1;
    localparam int CHAIN_BIT = 0;
    localparam int POL_BIT   = 30;
    localparam int NS_MSB    = 29;
    localparam int PH_MSB    = 2;
    localparam int IDX_BIT   = 8;
    localparam int IRQ_BITS  = 4;

    localparam logic [3:0] COUNT_MAX   = 4'hf;
    localparam logic [3:0] SAMPLES_CNT = 4'h3;

    // Sub-period slots of the 40 ns event period at an 8 ns clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int EVT_PERIOD_NS = 40;
    localparam logic [2:0] SLOT_LAST = 3'(EVT_PERIOD_NS / CLK_PERIOD_NS - 1);

    localparam logic [2:0] PH_0NS  = 3'h0;
    localparam logic [2:0] PH_8NS  = 3'h1;
    localparam logic [2:0] PH_16NS = 3'h2;
    localparam logic [2:0] PH_24NS = 3'h3;
    localparam logic [2:0] PH_32NS = 3'h4;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pti_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pti_apb_rsp_t;

    typedef struct packed {
        logic [31:0] sec;
        logic [29:0] ns;
    } pti_time_t;

    typedef struct packed {
        logic        pol;
        logic [29:0] ns;
        logic [31:0] sec;
        logic [2:0]  ph;
    } pti_sample_t;

    typedef struct packed {
        logic                      rise_detect_en;
        logic                      fall_detect_en;
        logic                      chain_last_unit;
        logic                      upstream_select;
        logic                      chain_enable;
        logic [3:0]                detected_edge_count;
        logic                      edge_count_overflow;
        logic                      prev_in;
        pti_sample_t [SAMPLES-1:0] smp;
    } pti_unit_t;

    typedef struct packed {
        pti_unit_t [UNITS-1:0] unit;
        logic                  idx;
        logic [2:0]            slot;
        logic [IRQ_BITS-1:0]   irq_stat;
        logic [IRQ_BITS-1:0]   irq_mask;
        logic [31:0]           rdata;
        logic                  err;
    } pti_state_t;

    localparam pti_state_t STATE_RESET = '0;

    function automatic logic [2:0] pti_phase_code(input logic [2:0] slot);
        case (slot)
            3'h0:    pti_phase_code = PH_0NS;
            3'h1:    pti_phase_code = PH_8NS;
            3'h2:    pti_phase_code = PH_16NS;
            3'h3:    pti_phase_code = PH_24NS;
            default: pti_phase_code = PH_32NS;
        endcase
    endfunction

endpackage

// *** bench/pti_evt_src.sv ***
// Event source model: drives event inputs and logs expected capture records
`timescale 1ns/100ps
`default_nettype none
module pti_evt_src
    import pti_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rstn,
    input  wire pti_time_t ptp_time,
    output logic [1:0]     event_in
);
    pti_sample_t log_q[$];
    int unsigned cyc;

    initial event_in = 2'b00;

    // Mirrors the free-running 40 ns slot count from reset
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            cyc <= 0;
        else
            cyc <= cyc + 1;
    end

    // One edge per clock at most; gap sets the edge rate
    task automatic toggle(input int u, input int gap);
        pti_sample_t s;
        event_in[u] <= ~event_in[u];
        @(posedge ref_clk);
        s.pol = event_in[u];
        s.ns  = ptp_time.ns;
        s.sec = ptp_time.sec;
        s.ph  = 3'(cyc % 5);
        log_q.push_back(s);
        repeat (gap - 1) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// *** bench/pti_timestamp_input_tb.sv ***
// Self-checking bench for the event timestamp input block
`timescale 1ns/100ps
`default_nettype none
module pti_timestamp_input_tb
    import pti_pkg::*;
;
    logic         ref_clk = 1'b0;
    logic         rstn;
    pti_apb_req_t req;
    pti_apb_rsp_t rsp;
    pti_time_t    ptp_time;
    logic [1:0]   event_in;
    logic         irq;
    int           err_total;
    int           samples_checked;
    logic [32:0]  note_q[$];
    logic [7:0]   bits[5] = '{8'h80, 8'h40, 8'h20, 8'h02, 8'h01};
    logic [7:0]   mode[3] = '{8'hc0, 8'hc1, 8'he1};

    always #4 ref_clk = ~ref_clk;

    pti_timestamp_input dut (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .clk_en   (1'b1),
        .apb_req  (req),
        .apb_rsp  (rsp),
        .ptp_time (ptp_time),
        .event_in (event_in),
        .irq      (irq)
    );

    pti_evt_src src (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .ptp_time (ptp_time),
        .event_in (event_in)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    function automatic logic [31:0] ctl(input logic [3:0] c, input logic o, input logic [7:0] b);
        ctl = {11'h0, c, o, 8'h0, b};
    endfunction

    // Random seconds keep every capture distinct
    always @(posedge ref_clk) begin
        ptp_time.ns  <= ptp_time.ns + 30'h8;
        ptp_time.sec <= xs(ptp_time.sec);
    end

    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        req <= '0;
        if (n >= 64) begin
            check(33'h0, 33'h1);
            finish_test;
        end
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        note_q.push_back({1'b0, exp});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic arm(input logic [7:0] b);
        wr(OFF_CTRL, {15'h0, 1'b1, 8'h0, b});
    endtask

    task automatic rd_smp(input int k, input pti_sample_t s);
        logic [11:0] o;
        o = SMP_STRIDE * 12'(k);
        rd(OFF_SMP_NS + o, {1'b0, s.pol, s.ns});
        rd(OFF_SMP_SEC + o, s.sec);
        rd(OFF_SMP_PH + o, {29'h0, s.ph});
    endtask

    // Result watcher: each completed read retires the oldest note
    always @(posedge ref_clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
            check({rsp.pslverr, rsp.prdata}, note_q.pop_front());
    end

    initial begin
        req <= '0;
        rstn <= 1'b0;
        ptp_time <= {32'h0000_656b, 30'h0};
        err_total = 0;
        samples_checked = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(OFF_CTRL, 32'h0);
        rd_smp(2, '0);
        check({32'h0, irq}, 33'h0);
        foreach (bits[i]) begin
            wr(OFF_CTRL, {24'h0, bits[i]});
            rd(OFF_CTRL, {24'h0, bits[i]});
        end
        note_q.push_back(33'h1_0000_0000);
        apb(1'b0, 12'h5f0, 32'h0);
        arm(8'h80);
        src.log_q.delete();
        repeat (4) src.toggle(0, 5);
        rd(OFF_CTRL, ctl(4'h2, 1'b0, 8'h80));
        rd_smp(0, src.log_q[0]);
        rd_smp(1, src.log_q[2]);
        rd_smp(2, '0);
        arm(8'hc0);
        src.log_q.delete();
        repeat (3) src.toggle(0, 1 + int'(ptp_time.sec[2:0]) % 5);
        rd(OFF_CTRL, ctl(4'h3, 1'b0, 8'hc0));
        for (int k = 0; k < 3; k++) rd_smp(k, src.log_q[k]);
        foreach (mode[i]) begin
            wr(OFF_IRQ_STAT, 32'hf);
            arm(mode[i]);
            repeat (16) src.toggle(0, 1);
            rd(OFF_CTRL, ctl(4'hf, mode[i] != 8'hc1, mode[i]));
            rd(OFF_IRQ_STAT, (mode[i] != 8'hc1) ? 32'h5 : 32'h1);
        end
        wr(OFF_IRQ_MASK, 32'h4);
        rd(OFF_IRQ_MASK, 32'h4);
        check({32'h0, irq}, 33'h1);
        wr(OFF_IRQ_STAT, 32'h4);
        check({32'h0, irq}, 33'h0);
        rd(OFF_IRQ_STAT, 32'h1);
        wr(OFF_INDEX, 32'h0000_0100);
        rd(OFF_CTRL, 32'h0);
        arm(8'h80);
        src.log_q.delete();
        repeat (2) src.toggle(1, 2);
        rd(OFF_CTRL, ctl(4'h1, 1'b0, 8'h80));
        rd_smp(0, src.log_q[0]);
        rd(OFF_IRQ_STAT, 32'h3);
        wr(OFF_INDEX, 32'h0);
        rd(OFF_CTRL, ctl(4'hf, 1'b1, 8'he1));
        // Unit 1 chained behind unit 0: armed only while unit 0 is full
        wr(OFF_INDEX, 32'h0000_0100);
        arm(8'h81);
        src.toggle(1, 2);
        wr(OFF_INDEX, 32'h0);
        arm(8'h80);
        wr(OFF_INDEX, 32'h0000_0100);
        repeat (2) src.toggle(1, 2);
        rd(OFF_CTRL, ctl(4'h1, 1'b0, 8'h81));
        finish_test;
    end
endmodule
`default_nettype wire
